// file: shared/crfmt_cfg.svh
// constants for the capture record ethernet formatter
`ifndef CRFMT_CFG_SVH
`define CRFMT_CFG_SVH
`define CRFMT_HDR_BYTES      16
`define CRFMT_EXT_BYTES      8
`define CRFMT_OFFPAD_BYTES   2
`define CRFMT_EXT_FLAG_BIT   7
`define CRFMT_CODE_LEGACY    7'h00
`define CRFMT_CODE_HDLC_POS  7'h01
`define CRFMT_CODE_ETH       7'h02
`define CRFMT_CODE_ATM       7'h03
`define CRFMT_CODE_AAL5      7'h04
`define CRFMT_CODE_COLOR_HDLC 7'h0A
`define CRFMT_CODE_COLOR_ETH 7'h0B
`define CRFMT_CODE_RAW_LINK  7'h18
`define CRFMT_CODE_RSV_LO    7'h20
`define CRFMT_CODE_RSV_HI    7'h2F
`define CRFMT_CODE_PAD       7'h30
`define CRFMT_SKIP_VALUE     8'h00
`define CRFMT_PAD_VALUE      8'h00
`define CRFMT_HDR_TYPE_IDX   4'h8
`define CRFMT_HDR_LAST_IDX   4'hF
`define CRFMT_EXT_LAST_IDX   4'h7
`endif

// file: shared/crfmt_pkg.sv
// types for the capture record ethernet formatter
`include "crfmt_cfg.svh"
package crfmt_pkg;
  // record layout codes carried in the low seven type bits
  typedef enum logic [6:0] {
    legacy_record_code     = `CRFMT_CODE_LEGACY,
    hdlc_pos_record_code   = `CRFMT_CODE_HDLC_POS,
    ethernet_record_code   = `CRFMT_CODE_ETH,
    atm_cell_record_code   = `CRFMT_CODE_ATM,
    aal5_frame_record_code = `CRFMT_CODE_AAL5,
    colored_hdlc_code      = `CRFMT_CODE_COLOR_HDLC,
    colored_ethernet_code  = `CRFMT_CODE_COLOR_ETH,
    raw_link_record_code   = `CRFMT_CODE_RAW_LINK,
    pad_record_code        = `CRFMT_CODE_PAD
  } crfmt_code_t;

  // emitter states
  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR, ST_EXT, ST_SKIP, ST_PAD, ST_FRAME
  } crfmt_state_t;

  // whole state of the formatter
  typedef struct packed {
    crfmt_state_t st;
    logic [3:0]   idx;
    logic [3:0]   ext_left;
    logic [15:0]  frm_left;
    logic [63:0]  ts;
    logic [7:0]   type_b;
    logic [7:0]   flags;
    logic [15:0]  rlen;
    logic [15:0]  loss_count_slot;
    logic [15:0]  wlen;
    logic [63:0]  eh_word;
    logic [7:0]   ob;
    logic         ov;
    logic         ol;
  } crfmt_regs_t;
endpackage

// file: shared/crfmt_hdr_if.sv
// carrier between the formatter and its type and length encoder
`timescale 1ns/10ps
interface crfmt_hdr_if;
  logic        color_mode;
  logic [3:0]  ext_count;
  logic [15:0] frame_len;
  logic [7:0]  type_byte;
  logic [15:0] rlen;
  modport fmt (output color_mode, output ext_count, output frame_len,
               input type_byte, input rlen);
  modport enc (input color_mode, input ext_count, input frame_len,
               output type_byte, output rlen);
endinterface

// file: rtl/crfmt_type_enc.sv
// type byte and record length encoder
`timescale 1ns/10ps
`include "crfmt_cfg.svh"
module crfmt_type_enc (
  // request and answer
  crfmt_hdr_if.enc hdr
);
  import crfmt_pkg::*;

  // code choice and extension flag
  always_comb begin
    hdr.type_byte = {(hdr.ext_count != 4'h0),
                     (hdr.color_mode ? colored_ethernet_code : ethernet_record_code)};
  end

  // fixed header plus extensions plus offset and pad plus frame
  always_comb begin
    hdr.rlen = 16'(`CRFMT_HDR_BYTES) + 16'({hdr.ext_count, 3'h0})
             + 16'(`CRFMT_OFFPAD_BYTES) + hdr.frame_len;
  end
endmodule

// file: rtl/crfmt_eth_formatter.sv
// capture record formatter for ethernet frames, one byte per transfer
// Notes on behaviour
// - ethernet records carry format code 2 in type bits six to zero
// - type bit seven is one exactly when extension headers follow
// - codes 0 to 24 name layouts, code 48 marks a padding record
// - codes 32 to 47 are reserved and never emitted here
// - colored ethernet, code 11, puts a color in the loss count slot
// - skipped-bytes byte is unimplemented; any value, host ignores it
// - one pad byte follows, then the frame, so layer three aligns
// - next record timestamp starts record-length bytes after this one's
// - each extension header is eight bytes; its top bit flags another
// - payload equals record length minus 16, extensions and 2
`timescale 1ns/10ps
`include "crfmt_cfg.svh"
module crfmt_eth_formatter (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // record request
  input  wire logic        start,
  output logic             start_ready,
  input  wire logic        color_mode,
  input  wire logic [63:0] timestamp,
  input  wire logic [7:0]  flags,
  input  wire logic [15:0] loss_count,
  input  wire logic [15:0] color_value,
  input  wire logic [15:0] wire_len,
  input  wire logic [15:0] frame_len,
  input  wire logic [3:0]  ext_count,
  // extension header words
  input  wire logic [63:0] eh_data,
  input  wire logic        eh_valid,
  output logic             eh_ready,
  // captured frame bytes
  input  wire logic [7:0]  fr_data,
  input  wire logic        fr_valid,
  output logic             fr_ready,
  // record byte stream to the host side
  output logic [7:0]       out_data,
  output logic             out_valid,
  output logic             out_last,
  input  wire logic        out_ready,
  // state
  output logic             busy
);
  import crfmt_pkg::*;

  crfmt_regs_t r_reg;
  crfmt_regs_t r_next;
  logic        advance;
  logic [63:0] ext_word;

  crfmt_hdr_if hdr ();

  // encoder fed from request ports
  assign hdr.color_mode = color_mode;
  assign hdr.ext_count  = ext_count;
  assign hdr.frame_len  = frame_len;

  crfmt_type_enc crfmt_type_enc_i (
    .hdr (hdr)
  );

  // byte of the fixed header: stamp little endian, counts big endian
  function automatic logic [7:0] hdr_byte(input crfmt_regs_t s, input logic [3:0] i);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      4'h8:    b = s.type_b;
      4'h9:    b = s.flags;
      4'hA:    b = s.rlen[15:8];
      4'hB:    b = s.rlen[7:0];
      4'hC:    b = s.loss_count_slot[15:8];
      4'hD:    b = s.loss_count_slot[7:0];
      4'hE:    b = s.wlen[15:8];
      4'hF:    b = s.wlen[7:0];
      default: b = s.ts[{i[2:0], 3'h0} +: 8];
    endcase
    return b;
  endfunction

  // handshakes
  assign advance     = !r_reg.ov || out_ready;
  assign start_ready = (r_reg.st == ST_IDLE) && advance;
  assign eh_ready    = advance && (r_reg.st == ST_EXT) && (r_reg.idx == 4'h0);
  assign fr_ready    = advance && (r_reg.st == ST_FRAME);
  assign ext_word    = (r_reg.idx == 4'h0) ? eh_data : r_reg.eh_word;

  // next state
  always_comb begin
    r_next = r_reg;
    if (advance) begin
      r_next.ov = 1'b0;
      r_next.ol = 1'b0;
      unique case (r_reg.st)
        ST_IDLE: begin
          if (start) begin
            r_next.st              = ST_HDR;
            r_next.idx             = 4'h0;
            r_next.ts              = timestamp;
            r_next.type_b          = hdr.type_byte;
            r_next.flags           = flags;
            r_next.rlen            = hdr.rlen;
            r_next.loss_count_slot = color_mode ? color_value : loss_count;
            r_next.wlen            = wire_len;
            r_next.ext_left        = ext_count;
            r_next.frm_left        = frame_len;
          end
        end
        ST_HDR: begin
          r_next.ob  = hdr_byte(r_reg, r_reg.idx);
          r_next.ov  = 1'b1;
          r_next.idx = r_reg.idx + 4'h1;
          if (r_reg.idx == `CRFMT_HDR_LAST_IDX) begin
            r_next.idx = 4'h0;
            r_next.st  = (r_reg.ext_left != 4'h0) ? ST_EXT : ST_SKIP;
          end
        end
        ST_EXT: begin
          if (r_reg.idx != 4'h0 || eh_valid) begin
            r_next.eh_word = ext_word;
            r_next.ob      = ext_word[63 - {r_reg.idx[2:0], 3'h0} -: 8];
            if (r_reg.idx == 4'h0) begin
              r_next.ob[`CRFMT_EXT_FLAG_BIT] = (r_reg.ext_left > 4'h1);
            end
            r_next.ov  = 1'b1;
            r_next.idx = r_reg.idx + 4'h1;
            if (r_reg.idx == `CRFMT_EXT_LAST_IDX) begin
              r_next.idx      = 4'h0;
              r_next.ext_left = r_reg.ext_left - 4'h1;
              if (r_reg.ext_left == 4'h1) begin
                r_next.st = ST_SKIP;
              end
            end
          end
        end
        ST_SKIP: begin
          r_next.ob = `CRFMT_SKIP_VALUE;
          r_next.ov = 1'b1;
          r_next.st = ST_PAD;
        end
        ST_PAD: begin
          r_next.ob = `CRFMT_PAD_VALUE;
          r_next.ov = 1'b1;
          if (r_reg.frm_left == 16'h0000) begin
            r_next.ol = 1'b1;
            r_next.st = ST_IDLE;
          end else begin
            r_next.st = ST_FRAME;
          end
        end
        ST_FRAME: begin
          if (fr_valid) begin
            r_next.ob       = fr_data;
            r_next.ov       = 1'b1;
            r_next.frm_left = r_reg.frm_left - 16'h0001;
            if (r_reg.frm_left == 16'h0001) begin
              r_next.ol = 1'b1;
              r_next.st = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs
  assign out_data  = r_reg.ob;
  assign out_valid = r_reg.ov;
  assign out_last  = r_reg.ol;
  assign busy      = (r_reg.st != ST_IDLE);

  // helper: bytes of the current record handed over so far
  logic [15:0] sent_reg;
  logic [15:0] frame_start_reg;
  logic        in_frame_reg;
  logic        color_mode_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sent_reg        <= 16'h0000;
      frame_start_reg <= 16'h0000;
      in_frame_reg    <= 1'b0;
    end else if (out_valid && out_ready) begin
      sent_reg     <= out_last ? 16'h0000 : sent_reg + 16'h0001;
      in_frame_reg <= (r_reg.st == ST_FRAME) && !out_last;
    end
  end

  // checks
  eth_code_a: assert property (@(posedge ref_clk) disable iff (rst)
    (r_reg.st == ST_HDR && r_reg.idx == `CRFMT_HDR_TYPE_IDX + 4'h1) |->
    (out_data[6:0] == (color_mode_q ? 7'h0B : 7'h02)))
    else $error("type byte holds a wrong format code");
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      color_mode_q <= 1'b0;
    end else if (start && start_ready) begin
      color_mode_q <= color_mode;
    end
  end
  ext_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    (start && start_ready) |=> (r_reg.type_b[7] == ($past(ext_count) != 4'h0)))
    else $error("extension flag does not match the extension count");
  code_known_a: assert property (@(posedge ref_clk) disable iff (rst)
    (r_reg.st != ST_IDLE) |-> (r_reg.type_b[6:0] <= 7'h18))
    else $error("type code outside the defined layouts");
  no_reserved_a: assert property (@(posedge ref_clk) disable iff (rst)
    (r_reg.st != ST_IDLE) |-> !(r_reg.type_b[6:0] inside {[7'h20:7'h2F]}))
    else $error("reserved format code emitted");
  color_slot_a: assert property (@(posedge ref_clk) disable iff (rst)
    (start && start_ready && color_mode) |=>
    (r_reg.loss_count_slot == $past(color_value) && r_reg.type_b[6:0] == 7'h0B))
    else $error("colored record lacks the color value");
  // pad sits at offset one modulo four, so the frame's network header lands on a word
  pad_then_frame_a: assert property (@(posedge ref_clk) disable iff (rst)
    (r_reg.st == ST_PAD && advance && r_reg.frm_left != 16'h0000) |=>
    (out_valid && out_data == `CRFMT_PAD_VALUE && r_reg.st == ST_FRAME
     && sent_reg[1:0] == 2'h1))
    else $error("pad byte not followed by the frame");
  rec_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    (out_valid && out_ready && out_last) |-> (sent_reg + 16'h0001 == r_reg.rlen))
    else $error("bytes sent differ from record length");
  ext_next_a: assert property (@(posedge ref_clk) disable iff (rst)
    (r_reg.st == ST_EXT && r_reg.idx == 4'h1 && out_valid) |->
    (out_data[7] == (r_reg.ext_left > 4'h1)))
    else $error("extension follow bit is wrong");
  piece_order_a: assert property (@(posedge ref_clk) disable iff (rst)
    (in_frame_reg && out_valid) |-> (r_reg.st == ST_FRAME || r_reg.st == ST_IDLE))
    else $error("record pieces out of order");
endmodule

// file: tb/crfmt_host_sink.sv
// host memory model that takes the record byte stream, at full pace or with stalls
`timescale 1ns/10ps
module crfmt_host_sink (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // pace control from the bench
  input  wire logic       slow,
  // record byte stream
  input  wire logic [7:0] out_data,
  input  wire logic       out_valid,
  input  wire logic       out_last,
  output logic            out_ready
);
  logic [7:0] byte_q[$];
  logic       last_q[$];
  int         n_done = 0;
  logic [1:0] phase  = 2'h0;
  logic       rdy    = 1'b0;

  assign out_ready = rdy;

  // accept every cycle, or one cycle in three when slow
  always @(negedge ref_clk) begin
    phase = (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    rdy   = !rst && (!slow || phase == 2'h0);
  end

  // store each accepted byte; the skip byte is stored but never interpreted
  always @(posedge ref_clk) begin
    if (!rst && out_valid && out_ready) begin
      byte_q.push_back(out_data);
      last_q.push_back(out_last);
      if (out_last) n_done++;
    end
  end
endmodule

// file: tb/capture_record_eth_formatter_test.sv
// self-checking bench for the ethernet capture record formatter
`timescale 1ns/10ps
`include "crfmt_cfg.svh"
module capture_record_eth_formatter_test;
  import crfmt_pkg::*;
  logic        ref_clk = 1'b0, rst = 1'b1, start = 1'b0, color_mode = 1'b0, slow = 1'b0;
  logic        start_ready, eh_ready, fr_ready, out_valid, out_last, out_ready, busy;
  logic [63:0] timestamp = 64'h0, eh_data = 64'h0;
  logic [7:0]  flags = 8'h00, fr_data = 8'h00, out_data;
  logic [15:0] loss_count = 16'h0BAD, color_value = 16'hC01C, wire_len = 16'h0, frame_len = 16'h0;
  logic [3:0]  ext_count = 4'h0;
  logic        eh_valid = 1'b0, fr_valid = 1'b0;
  int          fail_count = 0, n_compared = 0, cycles = 0, eh_idx = 0, fr_idx = 0;
  int          n_started = 0;

  always #25 ref_clk = ~ref_clk;

  crfmt_eth_formatter crfmt_eth_formatter_i (
    .ref_clk(ref_clk), .rst(rst), .start(start), .start_ready(start_ready),
    .color_mode(color_mode), .timestamp(timestamp), .flags(flags), .loss_count(loss_count),
    .color_value(color_value), .wire_len(wire_len), .frame_len(frame_len),
    .ext_count(ext_count), .eh_data(eh_data), .eh_valid(eh_valid), .eh_ready(eh_ready),
    .fr_data(fr_data), .fr_valid(fr_valid), .fr_ready(fr_ready), .out_data(out_data),
    .out_valid(out_valid), .out_last(out_last), .out_ready(out_ready), .busy(busy));

  crfmt_host_sink crfmt_host_sink_i (
    .ref_clk(ref_clk), .rst(rst), .slow(slow), .out_data(out_data),
    .out_valid(out_valid), .out_last(out_last), .out_ready(out_ready));

  // extension words and frame bytes advance on each taken transfer, restart with each record
  always @(posedge ref_clk) begin
    if (start && start_ready) begin
      n_started <= n_started + 1;
      eh_idx    <= 0;
      fr_idx    <= 0;
    end
    if (eh_valid && eh_ready) eh_idx <= eh_idx + 1;
    if (fr_valid && fr_ready) fr_idx <= fr_idx + 1;
  end
  // idle data lines show the inverse so stale values never pass
  always @(negedge ref_clk) begin
    eh_valid = busy && eh_idx < ext_count;
    eh_data  = {8'h01, 8'(eh_idx), 48'hC0FFEE012345} ^ {64{!eh_valid}};
    fr_valid = busy && fr_idx < frame_len;
    fr_data  = (8'hA0 + 8'(fr_idx)) ^ {8{!fr_valid}};
  end

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one whole record: request, wait for the last byte, compare every byte except the skip byte
  task automatic run_record(input logic cm, input logic [3:0] ne, input logic [15:0] fl,
                            input logic sl);
    logic [7:0]  exp_q[$], got[$];
    logic        lst[$];
    logic [15:0] rl, slot;
    logic [63:0] hw, ew;
    int          base, done, k, j, sk, st0;
    rl   = 16'(`CRFMT_HDR_BYTES + `CRFMT_EXT_BYTES * ne + `CRFMT_OFFPAD_BYTES) + fl;
    slot = cm ? color_value : loss_count;
    sk   = `CRFMT_HDR_BYTES + `CRFMT_EXT_BYTES * ne;
    color_mode = cm;
    ext_count  = ne;
    frame_len  = fl;
    slow       = sl;
    timestamp  = 64'h0123456789ABCDEF + 64'(ne);
    flags      = 8'h5A;
    wire_len   = fl + 16'h0004;
    base       = crfmt_host_sink_i.byte_q.size();
    done       = crfmt_host_sink_i.n_done;
    st0        = n_started;
    start      = 1'b1;
    // hold the request until an edge has taken it
    for (k = 0; k < 100 && n_started == st0; k++) @(negedge ref_clk);
    start = 1'b0;
    for (k = 0; k < 3000 && crfmt_host_sink_i.n_done == done; k++) @(negedge ref_clk);
    for (k = base; k < crfmt_host_sink_i.byte_q.size(); k++) begin
      got.push_back(crfmt_host_sink_i.byte_q[k]);
      lst.push_back(crfmt_host_sink_i.last_q[k]);
    end
    for (k = 0; k < 8; k++) exp_q.push_back(timestamp[8*k +: 8]);
    hw = {ne != 4'h0, cm ? colored_ethernet_code : ethernet_record_code, flags, rl, slot,
          wire_len};
    for (k = 0; k < 8; k++) exp_q.push_back(hw[63 - 8*k -: 8]);
    for (k = 0; k < ne; k++) begin
      ew = {k + 1 < ne, 7'h01, 8'(k), 48'hC0FFEE012345};
      for (j = 0; j < 8; j++) exp_q.push_back(ew[63 - 8*j -: 8]);
    end
    exp_q.push_back(8'h00);
    exp_q.push_back(`CRFMT_PAD_VALUE);
    for (k = 0; k < fl; k++) exp_q.push_back(8'hA0 + 8'(k));
    check(16'(got.size()), rl);
    check({8'h00, got[8]}, {8'h00, exp_q[8]});
    check(16'(got[8][6:0] inside {[7'h20:7'h2F]}), 16'h0000);
    check({got[12], got[13]}, slot);
    check({8'h00, got[sk+1]}, 16'h0000);
    check(16'(busy), 16'h0000);
    for (k = 0; k < exp_q.size() && k < got.size(); k++) begin
      if (k != sk) check({8'h00, got[k]}, {8'h00, exp_q[k]});
      check(16'(lst[k]), 16'(k == exp_q.size() - 1));
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // reset, then records of both codes, extension counts 0, 1, 2 and 15, stalls, back to back
  initial begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    check({13'h0000, out_valid, busy, start_ready}, 16'h0001);
    run_record(1'b0, 4'h0, 16'h0004, 1'b0);
    run_record(1'b0, 4'h2, 16'h0005, 1'b1);
    run_record(1'b1, 4'h1, 16'h0000, 1'b0);
    run_record(1'b1, 4'h0, 16'h0003, 1'b1);
    run_record(1'b0, 4'hF, 16'h0001, 1'b0);
    print_verdict();
  end
endmodule
